// File: core/dsr_status_core.sv
// Host status, error result and interrupt cause reporting for a disk controller
`timescale 1ns/1ps
`default_nettype none

module dsr_status_core
	import dsr_pkg::*;
#(
	parameter int unsigned DEPTH = DSR_DEPTH
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rst_b,
	input  wire logic                  cs_b,
	input  wire logic                  rd_b,
	input  wire logic                  wr_b,
	input  wire logic                  reg_select,
	input  wire logic [7:0]            data_in,
	output logic      [7:0]            data_out,
	output logic                       data_oe,
	input  wire dsr_event_type         events,
	input  wire logic                  drive_not_ready,
	input  wire logic                  xfer_to_host,
	input  wire logic                  xfer_from_host,
	output logic                       cmd_start,
	output logic      [7:0]            cmd_code,
	output logic                       int_req,
	output dsr_status_type             status
);

	// ==========================================================
	// Host strobe synchronisers
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic [7:0] data_a;
	logic [7:0] data_b;
	logic       rd_q;
	logic       wr_q;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sync_a <= 4'hf;
			sync_b <= 4'hf;
			data_a <= DSR_ZERO_BYTE;
			data_b <= DSR_ZERO_BYTE;
		end else begin
			sync_a <= {cs_b, rd_b, wr_b, ~reg_select};
			sync_b <= sync_a;
			data_a <= data_in;
			data_b <= data_a;
		end
	end

	logic cs_s;
	logic rd_s;
	logic wr_s;
	logic sel_s;
	assign cs_s  = ~sync_b[3];
	assign rd_s  = ~sync_b[2];
	assign wr_s  = ~sync_b[1];
	assign sel_s = ~sync_b[0];

	// Strobes both low are inhibited
	logic rd_act;
	logic wr_act;
	assign rd_act = cs_s & rd_s & ~wr_s;
	assign wr_act = cs_s & wr_s & ~rd_s;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			rd_q <= rd_act;
			wr_q <= wr_act;
		end
	end

	logic rd_rise;
	logic wr_rise;
	logic rd_end;
	assign rd_rise = rd_act & ~rd_q;
	assign wr_rise = wr_act & ~wr_q;
	assign rd_end  = rd_q & ~rd_act;

	logic cmd_wr;
	logic buf_wr;
	logic buf_rd;
	assign cmd_wr = wr_rise & sel_s;
	assign buf_wr = wr_rise & ~sel_s;
	assign buf_rd = rd_end & ~sel_s;

	// ==========================================================
	// Command decode
	logic          is_aux;
	logic          disk_cmd;
	logic          accept;
	logic          soft_rst;
	logic          clear_cmd_end;
	logic          mask_set;
	logic          clr_buf;
	dsr_state_type state;
	logic [2:0]    rst_cnt;

	assign is_aux   = data_b[DSR_CMD_HI:DSR_CMD_LO] == DSR_CMD_AUX;
	assign disk_cmd = cmd_wr & ~is_aux;
	assign accept   = disk_cmd & (state == DSR_IDLE);
	assign soft_rst = cmd_wr & is_aux & data_b[DSR_AUX_SOFT_RST];
	assign clear_cmd_end     = cmd_wr & is_aux & data_b[DSR_AUX_CLEAR_CMD_END];
	assign mask_set = cmd_wr & is_aux & data_b[DSR_AUX_MASK];
	assign clr_buf  = cmd_wr & is_aux & data_b[DSR_AUX_CLR_BUF];

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmd_start <= 1'b0;
			cmd_code  <= DSR_ZERO_BYTE;
		end else begin
			cmd_start <= accept;
			if (accept) begin
				cmd_code <= data_b;
			end
		end
	end

	// ==========================================================
	// Busy and reset sequencing
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state   <= DSR_RESET;
			rst_cnt <= DSR_RESET_LOAD;
		end else begin
			case (state)
				DSR_RESET: begin
					if (rst_cnt == 3'h0) begin
						state <= DSR_IDLE;
					end else begin
						rst_cnt <= rst_cnt - 3'h1;
					end
				end
				DSR_IDLE: begin
					if (soft_rst) begin
						state   <= DSR_RESET;
						rst_cnt <= DSR_RESET_LOAD;
					end else if (accept) begin
						state <= DSR_BUSY;
					end
				end
				default: begin
					if (soft_rst) begin
						state   <= DSR_RESET;
						rst_cnt <= DSR_RESET_LOAD;
					end else if (events.cmd_done) begin
						state <= DSR_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Status flags
	logic [1:0] cmd_end;
	logic       sense_request;
	logic       sense_mask;
	logic       format_lost;
	logic       id_crc_fault;
	logic       no_match;
	logic       in_reset;
	logic       sense_cmd;

	assign in_reset  = (state == DSR_RESET);
	assign sense_cmd = accept & dsr_is_sense(data_b);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmd_end <= DSR_END_NONE;
		end else if (events.cmd_done && state == DSR_BUSY) begin
			cmd_end <= events.cmd_outcome;
		end else if (accept || clear_cmd_end || in_reset) begin
			cmd_end <= DSR_END_NONE;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sense_request <= 1'b0;
		end else if (events.seek_end || events.drive_fault || events.ready_chg) begin
			sense_request <= 1'b1;
		end else if (sense_cmd || in_reset) begin
			sense_request <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sense_mask <= 1'b0;
		end else if (mask_set) begin
			sense_mask <= 1'b1;
		end else if (events.cmd_done || in_reset) begin
			sense_mask <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			format_lost  <= 1'b0;
			id_crc_fault <= 1'b0;
			no_match     <= 1'b0;
		end else begin
			format_lost  <= events.format_lost | (format_lost & ~accept & ~in_reset);
			id_crc_fault <= events.id_crc | (id_crc_fault & ~accept & ~in_reset);
			no_match     <= events.no_match | (no_match & ~accept & ~in_reset);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			status <= '0;
		end else begin
			status.controller_active <= (state != DSR_IDLE);
			status.cmd_end           <= cmd_end;
			status.sense_request     <= sense_request;
			status.format_lost       <= format_lost;
			status.id_crc_fault      <= id_crc_fault;
			status.no_match          <= no_match;
			status.transfer_request  <= (state == DSR_BUSY) &
				(xfer_to_host | xfer_from_host);
		end
	end

	assign int_req = (|cmd_end) | (sense_request & ~sense_mask);

	// ==========================================================
	// Error result byte and interrupt cause
	dsr_error_type err;
	dsr_error_type err_hold;
	dsr_cause_type cause;

	// Same-cycle event wins over the clear
	assign err_hold = (accept || in_reset) ? '0 : err;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			err <= '0;
		end else begin
			err.cylinder_end_hit      <= err_hold.cylinder_end_hit | events.cyl_end;
			err.buffer_overrun_flag   <= err_hold.buffer_overrun_flag | events.overrun;
			err.data_field_fault      <= err_hold.data_field_fault | events.data_crc;
			err.equipment_fault       <= err_hold.equipment_fault | events.drive_fault;
			err.drive_offline         <= drive_not_ready;
			err.sector_missing        <= err_hold.sector_missing | events.sector_missing;
			err.write_protected_fault <= err_hold.write_protected_fault | events.write_prot;
			err.data_mark_missing     <= err_hold.data_mark_missing | events.mark_missing;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cause <= '0;
		end else if (events.seek_end || events.ready_chg || events.drive_fault) begin
			cause.seek_finished   <= events.seek_end;
			cause.ready_change    <= events.ready_chg;
			cause.seek_fault      <= events.seek_err;
			cause.equipment_fault <= events.drive_fault;
			cause.drive_offline   <= drive_not_ready;
			cause.drive_id        <= events.unit;
		end
	end

	// ==========================================================
	// Data buffer: parameters in, results out
	localparam logic [DSR_PTR_W:0] FULL_CNT = (DSR_PTR_W + 1)'(DEPTH);
	logic [7:0]           mem [DEPTH];
	logic [DSR_PTR_W-1:0] wptr;
	logic [DSR_PTR_W-1:0] rptr;
	logic [DSR_PTR_W:0]   count;
	logic                 load_err;
	logic                 load_cause;
	logic                 do_push;
	logic                 do_pop;

	assign load_err   = events.cmd_done & (state == DSR_BUSY) & ~dsr_is_sense(cmd_code);
	assign load_cause = events.cmd_done & (state == DSR_BUSY) & dsr_is_sense(cmd_code);
	assign do_push    = load_err | load_cause | (buf_wr & (count != FULL_CNT));
	assign do_pop     = buf_rd & (count != '0);

	always_ff @(posedge clk_sys) begin
		if (do_push) begin
			mem[(load_err || load_cause) ? '0 : wptr] <= load_err ? 8'(err) :
				(load_cause ? 8'(cause) : data_b);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
		end else if (clr_buf || in_reset || load_err || load_cause) begin
			// Result phase restarts buffer with the result byte first
			wptr  <= (load_err || load_cause) ? DSR_ONE_PTR : '0;
			rptr  <= '0;
			count <= (load_err || load_cause) ? DSR_ONE_CNT : '0;
		end else begin
			if (do_push) begin
				wptr <= wptr + DSR_ONE_PTR;
			end
			if (do_pop) begin
				rptr <= rptr + DSR_ONE_PTR;
			end
			count <= count + (do_push ? DSR_ONE_CNT : '0) - (do_pop ? DSR_ONE_CNT : '0);
		end
	end

	// ==========================================================
	// Host read data
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			data_out <= DSR_ZERO_BYTE;
			data_oe  <= 1'b0;
		end else begin
			data_oe <= rd_act;
			if (rd_act && sel_s) begin
				data_out <= status;
			end else if (rd_act) begin
				data_out <= (count != '0) ? mem[rptr] : DSR_ZERO_BYTE;
			end
		end
	end

	// ==========================================================
	// Checks
	a_busy_blocks_cmd: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(disk_cmd && state != DSR_IDLE) |=> !cmd_start)
		else $error("disk command accepted while busy");

	a_cmd_sets_busy: assert property (@(posedge clk_sys) disable iff (!rst_b)
		accept |=> ##1 status.controller_active)
		else $error("busy not shown after command");

	a_cmd_end_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(clear_cmd_end && !(events.cmd_done && state == DSR_BUSY)) |=> cmd_end == DSR_END_NONE)
		else $error("command end not cleared");

	a_int_equation: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(cmd_end == DSR_END_NONE && !sense_request) |-> !int_req)
		else $error("spurious interrupt");

	a_sense_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		events.seek_end |=> ##1 status.sense_request)
		else $error("sense request missing");

	a_err_cleared: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(accept && !events.cyl_end && !events.write_prot) |=>
		!err.cylinder_end_hit && !err.write_protected_fault)
		else $error("error flags survive new command");

	a_inhibit_rw: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(rd_s && wr_s) |-> !do_pop && !buf_wr)
		else $error("simultaneous strobes acted on");

	a_outcome_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(events.cmd_done && state == DSR_BUSY) |=> cmd_end == $past(events.cmd_outcome))
		else $error("outcome not captured");

endmodule

`default_nettype wire

// File: pkg/dsr_pkg.sv
// Constants and carrier types for the disk controller status reporting block
`default_nettype none

package dsr_pkg;

	localparam int unsigned DSR_DATA_W    = 8;
	localparam int unsigned DSR_DEPTH     = 8;
	localparam int unsigned DSR_PTR_W     = 3;
	localparam int unsigned DSR_UNIT_W    = 3;
	localparam logic [7:0]  DSR_ZERO_BYTE = 8'h00;
	localparam logic [DSR_PTR_W:0] DSR_ONE_CNT = 4'h1;
	localparam logic [DSR_PTR_W-1:0] DSR_ONE_PTR = 3'h1;

	// Command byte fields
	localparam int unsigned DSR_CMD_HI = 7;
	localparam int unsigned DSR_CMD_LO = 4;
	localparam logic [3:0]  DSR_CMD_AUX   = 4'h0;
	localparam logic [3:0]  DSR_CMD_SENSE = 4'h1;
	localparam int unsigned DSR_AUX_SOFT_RST = 3;
	localparam int unsigned DSR_AUX_CLR_BUF  = 2;
	localparam int unsigned DSR_AUX_MASK     = 1;
	localparam int unsigned DSR_AUX_CLEAR_CMD_END     = 0;

	// Outcome encodings
	localparam logic [1:0] DSR_END_NONE     = 2'h0;
	localparam logic [1:0] DSR_END_ABNORMAL = 2'h1;
	localparam logic [1:0] DSR_END_NORMAL   = 2'h2;
	localparam logic [1:0] DSR_END_INVALID  = 2'h3;

	// Reset function length in clocks
	localparam int unsigned DSR_RESET_CYCLES = 4;
	localparam logic [2:0]  DSR_RESET_LOAD   = 3'(DSR_RESET_CYCLES - 1);

	// Throughput: 2.5 MB/s at 10 MHz is one byte every 4 clocks
	localparam int unsigned DSR_CLK_HZ       = 10_000_000;
	localparam int unsigned DSR_BYTES_PER_S  = 2_500_000;
	localparam int unsigned DSR_BYTE_CYCLES  = DSR_CLK_HZ / DSR_BYTES_PER_S;

	typedef struct packed {
		logic       controller_active;
		logic [1:0] cmd_end;
		logic       sense_request;
		logic       format_lost;
		logic       id_crc_fault;
		logic       no_match;
		logic       transfer_request;
	} dsr_status_type;

	typedef struct packed {
		logic cylinder_end_hit;
		logic buffer_overrun_flag;
		logic data_field_fault;
		logic equipment_fault;
		logic drive_offline;
		logic sector_missing;
		logic write_protected_fault;
		logic data_mark_missing;
	} dsr_error_type;

	typedef struct packed {
		logic                  seek_finished;
		logic                  ready_change;
		logic                  seek_fault;
		logic                  equipment_fault;
		logic                  drive_offline;
		logic [DSR_UNIT_W-1:0] drive_id;
	} dsr_cause_type;

	// Events reported by the command processor
	typedef struct packed {
		logic                  cmd_done;
		logic [1:0]            cmd_outcome;
		logic                  seek_end;
		logic                  ready_chg;
		logic                  seek_err;
		logic                  format_lost;
		logic                  id_crc;
		logic                  no_match;
		logic                  cyl_end;
		logic                  overrun;
		logic                  data_crc;
		logic                  drive_fault;
		logic                  sector_missing;
		logic                  write_prot;
		logic                  mark_missing;
		logic [DSR_UNIT_W-1:0] unit;
	} dsr_event_type;

	typedef enum logic [1:0] {
		DSR_IDLE  = 2'b00,
		DSR_RESET = 2'b01,
		DSR_BUSY  = 2'b10
	} dsr_state_type;

	function automatic logic dsr_is_sense(input logic [7:0] cmd);
		return cmd[DSR_CMD_HI:DSR_CMD_LO] == DSR_CMD_SENSE;
	endfunction

endpackage

`default_nettype wire

// File: tb/dsr_host_model.sv
// Host microprocessor model for the controller's parallel bus
`timescale 1ns/1ps
`default_nettype none

module dsr_host_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	output logic            cs_b,
	output logic            rd_b,
	output logic            wr_b,
	output logic            reg_select,
	output logic [7:0]      data_in
);
	initial begin
		cs_b       = 1'b1;
		rd_b       = 1'b1;
		wr_b       = 1'b1;
		reg_select = 1'b0;
		data_in    = 8'h00;
	end

	// ============================================
	// Write: strobe low 4 clocks, then high 4 clocks
	task automatic bus_write(input logic sel, input logic [7:0] val);
		@(posedge clk_sys);
		cs_b       <= 1'b0;
		wr_b       <= 1'b0;
		reg_select <= sel;
		data_in    <= val;
		repeat (4) @(posedge clk_sys);
		cs_b    <= 1'b1;
		wr_b    <= 1'b1;
		data_in <= ~val;
		repeat (4) @(posedge clk_sys);
	endtask

	// ============================================
	// Read: hold strobe until output enable seen, at least 3 clocks
	task automatic bus_read(input logic sel, output logic [7:0] val);
		int n;
		val = 8'hxx;
		n = 0;
		@(posedge clk_sys);
		cs_b       <= 1'b0;
		rd_b       <= 1'b0;
		reg_select <= sel;
		do begin
			@(posedge clk_sys);
			n++;
		end while ((data_oe !== 1'b1 || n < 3) && n < 12);
		if (data_oe === 1'b1) begin
			val = data_out;
		end
		cs_b <= 1'b1;
		rd_b <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask

	// ============================================
	// Both strobes low at once, on purpose
	task automatic bus_clash(input logic [7:0] val);
		@(posedge clk_sys);
		cs_b       <= 1'b0;
		rd_b       <= 1'b0;
		wr_b       <= 1'b0;
		reg_select <= 1'b1;
		data_in    <= val;
		repeat (4) @(posedge clk_sys);
		cs_b    <= 1'b1;
		rd_b    <= 1'b1;
		wr_b    <= 1'b1;
		data_in <= ~val;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule

`default_nettype wire

// File: tb/test_disk_ctrl_status_reporting.sv
// Self-checking bench for the disk controller status reporting block
`timescale 1ns/1ps
`default_nettype none

module test_disk_ctrl_status_reporting;
	import dsr_pkg::*;

	typedef struct packed {
		dsr_event_type ev;
		logic [7:0]    err;
		logic [7:0]    stat;
	} dsr_row_type;

	logic           clk_sys = 1'b0;
	logic           rst_b = 1'b0;
	logic           cs_b;
	logic           rd_b;
	logic           wr_b;
	logic           reg_select;
	logic [7:0]     data_in;
	logic [7:0]     data_out;
	logic           data_oe;
	dsr_event_type  ev = '0;
	logic           not_ready = 1'b0;
	logic           to_host = 1'b0;
	logic           from_host = 1'b0;
	logic           cmd_start;
	logic [7:0]     cmd_code;
	logic           int_req;
	dsr_status_type status;
	logic [7:0]     last_code = 8'h00;
	logic [7:0]     v;
	int             starts = 0;
	int             bad_count = 0;
	int             compares = 0;
	dsr_row_type    rows [4];

	always #50 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		if (cmd_start === 1'b1) begin
			starts++;
			last_code = cmd_code;
		end
	end

	dsr_status_core DUT (
		.clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
		.reg_select(reg_select), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .events(ev), .drive_not_ready(not_ready),
		.xfer_to_host(to_host), .xfer_from_host(from_host), .cmd_start(cmd_start),
		.cmd_code(cmd_code), .int_req(int_req), .status(status)
	);

	dsr_host_model host (
		.clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe), .cs_b(cs_b),
		.rd_b(rd_b), .wr_b(wr_b), .reg_select(reg_select), .data_in(data_in)
	);

	// ============================================
	// Shared tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s saw %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic pulse(input dsr_event_type e);
		@(posedge clk_sys);
		ev <= e;
		@(posedge clk_sys);
		ev <= '0;
	endtask

	task automatic finish_cmd(input logic [1:0] outcome);
		dsr_event_type e;
		e = '0;
		e.cmd_done = 1'b1;
		e.cmd_outcome = outcome;
		pulse(e);
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic wait_idle();
		int n;
		for (n = 0; n < 40 && status.controller_active !== 1'b0; n++) @(posedge clk_sys);
		check({7'h0, status.controller_active}, 8'h00, "busy clear");
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		conclude();
	end

	// ============================================
	// Main sequence
	initial begin
		int i;
		dsr_event_type e;
		rows[0] = '{ev: '{cmd_outcome: DSR_END_NORMAL, default: '0}, err: 8'h00, stat: 8'h40};
		rows[1] = '{ev: '{cmd_outcome: DSR_END_ABNORMAL, cyl_end: 1'b1, data_crc: 1'b1,
			sector_missing: 1'b1, mark_missing: 1'b1, format_lost: 1'b1, default: '0},
			err: 8'ha5, stat: 8'h28};
		rows[2] = '{ev: '{cmd_outcome: DSR_END_ABNORMAL, overrun: 1'b1, drive_fault: 1'b1,
			write_prot: 1'b1, id_crc: 1'b1, no_match: 1'b1, default: '0},
			err: 8'h52, stat: 8'h36};
		rows[3] = '{ev: '{cmd_outcome: DSR_END_INVALID, default: '0}, err: 8'h00, stat: 8'h70};
		repeat (8) @(posedge clk_sys);
		check(status, 8'h00, "status in reset");
		check({7'h0, int_req}, 8'h00, "int in reset");
		rst_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check({7'h0, status.controller_active}, 8'h01, "busy after reset");
		wait_idle();
		$display("test reset done");

		host.bus_clash(8'hb0);
		check(8'(starts), 8'h00, "clash ignored");
		host.bus_write(1'b0, 8'h3c);
		host.bus_write(1'b0, 8'hc3);
		host.bus_read(1'b0, v);
		check(v, 8'h3c, "parameter one");
		host.bus_read(1'b0, v);
		check(v, 8'hc3, "parameter two");
		check({7'h0, data_oe}, 8'h00, "output released");
		for (i = 0; i <= DSR_DEPTH; i++) begin
			host.bus_write(1'b0, 8'(i + 16));
		end
		for (i = 0; i < DSR_DEPTH; i++) begin
			host.bus_read(1'b0, v);
			check(v, 8'(i + 16), "buffer order");
		end
		host.bus_read(1'b0, v);
		check(v, 8'h00, "overflow dropped");
		host.bus_write(1'b0, 8'h5a);
		host.bus_write(1'b1, 8'h04);
		host.bus_read(1'b0, v);
		check(v, 8'h00, "buffer cleared");
		$display("test buffer done");

		for (i = 0; i < 4; i++) begin
			host.bus_write(1'b1, 8'hb0);
			check(8'(starts), 8'(i + 1), "command taken");
			pulse(rows[i].ev);
			finish_cmd(rows[i].ev.cmd_outcome);
			check(status, rows[i].stat, "status port");
			check({7'h0, int_req}, 8'h01, "int on end");
			host.bus_read(1'b1, v);
			check(v, rows[i].stat, "status read");
			host.bus_read(1'b0, v);
			check(v, rows[i].err, "error byte");
			host.bus_read(1'b0, v);
			check(v, 8'h00, "empty buffer");
			$display("test row %0d done", i);
		end

		not_ready <= 1'b1;
		e = '0;
		e.seek_end = 1'b1;
		e.ready_chg = 1'b1;
		e.seek_err = 1'b1;
		e.unit = 3'h5;
		pulse(e);
		repeat (2) @(posedge clk_sys);
		check({7'h0, status.sense_request}, 8'h01, "sense pending");
		host.bus_write(1'b1, 8'h10);
		finish_cmd(DSR_END_NORMAL);
		host.bus_read(1'b0, v);
		check(v, 8'hed, "cause byte");
		check(status, 8'h40, "sense cleared");
		host.bus_write(1'b1, 8'h01);
		check(status, 8'h00, "end cleared");
		check({7'h0, int_req}, 8'h00, "int idle");
		e = '0;
		e.seek_end = 1'b1;
		pulse(e);
		repeat (2) @(posedge clk_sys);
		check({7'h0, int_req}, 8'h01, "int on request");
		host.bus_write(1'b1, 8'h02);
		check({7'h0, int_req}, 8'h00, "int masked");
		check(status, 8'h10, "request kept");
		host.bus_write(1'b1, 8'h08);
		wait_idle();
		check(status, 8'h00, "soft reset");
		$display("test sense and auxiliary done");

		host.bus_write(1'b1, 8'hf0);
		check({7'h0, status.controller_active}, 8'h01, "busy on command");
		from_host <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check({7'h0, status.transfer_request}, 8'h01, "write request");
		from_host <= 1'b0;
		to_host <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check({7'h0, status.transfer_request}, 8'h01, "read request");
		to_host <= 1'b0;
		i = starts;
		host.bus_write(1'b1, 8'hb0);
		check(8'(starts - i), 8'h00, "ignored while busy");
		check(last_code, 8'hf0, "code kept");
		finish_cmd(DSR_END_NORMAL);
		wait_idle();
		check(status, 8'h40, "end before reset");
		$display("test busy done");

		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check(status, 8'h00, "status in second reset");
		check({7'h0, int_req}, 8'h00, "int in second reset");
		rst_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check({7'h0, status.controller_active}, 8'h01, "busy after second reset");
		wait_idle();
		check(status, 8'h00, "end cleared by reset");
		$display("test second reset done");
		conclude();
	end
endmodule

`default_nettype wire
